// *** core/aoc_pkg.sv ***
// Purpose: shared constants for the converter output and control pin logic
// Assumes: 200 MHz system clock, Avalon-MM register access
// Notes:   byte offsets are word aligned
package aoc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int WAKE_SB_US     = 25;
  localparam int WAKE_PD_US     = 500;
  localparam int WAKE_SB_CYC    = WAKE_SB_US * CLK_MHZ;
  localparam int WAKE_PD_CYC    = WAKE_PD_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  localparam int SMP_W          = 12;
  localparam int PAIRS          = SMP_W / 2;
  localparam int LAT_W          = 5;
  localparam logic [LAT_W-1:0] LAT_LOW  = 5'h0a;
  localparam logic [LAT_W-1:0] LAT_GAIN = 5'h10;
  localparam logic [LAT_W-1:0] LAT_FULL = 5'h11;
  localparam logic [LAT_W-1:0] LAT_ONE  = 5'h01;
  localparam int PIPE_DEPTH     = 18;
  // ----------------------------------------------------------------
  // format select levels
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_TC_DDR = 2'h0;
  localparam logic [1:0] FMT_TC_PAR = 2'h1;
  localparam logic [1:0] FMT_OB_PAR = 2'h2;
  localparam logic [1:0] FMT_OB_DDR = 2'h3;
  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  localparam int CFG_W          = 5;
  localparam int CFG_LOWLAT_OFF = 0;
  localparam int CFG_GAIN_EN    = 1;
  localparam int CFG_OFFS_EN    = 2;
  localparam int CFG_READOUT    = 3;
  localparam int CFG_LONG_PATH  = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  localparam int STAT_W         = 7;
  // ----------------------------------------------------------------
  // bus map and serial map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [7:0] SER_RST_ADDR = 8'h00;
  localparam logic [7:0] SER_CFG_ADDR = 8'h01;
  localparam int SER_RST_BIT    = 7;
  localparam logic [3:0] SER_ADDR_LAST = 4'h7;
  localparam logic [3:0] SER_WORD_LAST = 4'hf;
  localparam logic [3:0] SER_ONE       = 4'h1;
endpackage

// *** core/aoc_sync2.sv ***
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module aoc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** core/aoc_top.sv ***
// Purpose: output formatting, latency and control pins of a 12-bit converter
// Assumes: sample clock and all pins are asynchronous to clock
// Notes:   registers over Avalon-MM, also writable by the serial pins
//
// Summary of operation
// R01 - range pin shows out-of-range when readout bit 0, serial read data when 1
// R02 - serial clock pin used only while reset pin low, ignored while high
// R03 - serial data pin is serial input while reset pin low
// R04 - serial data pin becomes standby control while reset pin high
// R05 - active-low serial select used only while reset pin low
// R06 - reset pin high holds configuration at defaults
// R07 - controller initialises registers by reset pulse or software reset
// R08 - output drivers enabled only while output-enable pin high
// R09 - each of six pairs carries one even and one odd bit
// R10 - differential mode drives a differential output clock with data
// R11 - parallel mode gives 12-bit word, one clock, complement clock unused
// R12 - format pin picks number format and interface type
// R13 - low-latency default: sample out 10 sample clocks after taken
// R14 - latency 16 with low latency off, gain on, offset off
// R15 - latency 17 with low latency off, gain and offset on
// R16 - valid data within 25 us after leaving standby
// R17 - valid data within 500 us after leaving power-down
// R18 - long output path adds one cycle of latency
// R19 - format pin four levels: tc-ddr, tc-par, ob-par, ob-ddr
// R20 - one new word per sample clock, range flag aligned with it
// R21 - capture logic deinterleaves pairs using the output clock
`timescale 1ns/100ps
module aoc_top #(
  parameter int WAKE_SB_CYC = aoc_pkg::WAKE_SB_CYC,
  parameter int WAKE_PD_CYC = aoc_pkg::WAKE_PD_CYC,
  parameter int WAKE_W      = 17
) (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     sample_clock_pos,
  input  wire logic                     sample_clock_neg,
  input  wire logic [aoc_pkg::SMP_W-1:0] conv_sample,
  input  wire logic                     conv_over_range,
  input  wire logic                     cfg_reset_pin,
  input  wire logic                     serial_clock_pin,
  input  wire logic                     serial_in_line,
  input  wire logic                     serial_select_n,
  input  wire logic                     out_enable_pin,
  input  wire logic [1:0]               format_select_pin,
  input  wire logic                     full_power_down,
  output logic      [aoc_pkg::PAIRS-1:0] pair_true,
  output logic      [aoc_pkg::PAIRS-1:0] pair_comp,
  output logic                          pair_oe,
  output logic                          out_clock_true,
  output logic                          out_clock_comp,
  output logic                          out_clock_comp_oe,
  output logic      [aoc_pkg::SMP_W-1:0] parallel_data,
  output logic                          parallel_out_clock,
  output logic                          parallel_oe,
  output logic                          range_flag_or_readout,
  output logic                          data_valid,
  output logic                          standby_active
);
  initial begin
    if (WAKE_SB_CYC < 1 || WAKE_PD_CYC < 1 || WAKE_PD_CYC >= 2**WAKE_W || WAKE_SB_CYC >= 2**WAKE_W)
      $error("wake counts do not fit the wake counter");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = aoc_pkg::SMP_W + 11;
  logic [SW-1:0] pins_s;
  logic [aoc_pkg::SMP_W-1:0] smp_s;
  logic sclk_s, serial_in_line_s, sen_n_s, rst_pin_s, oe_s, pdn_s, ovr_s, sck_pos_s, sck_neg_s;
  logic [1:0] fmt_s;

  aoc_sync2 #(.WIDTH(SW)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({sample_clock_pos, sample_clock_neg, serial_clock_pin, serial_in_line, serial_select_n,
              cfg_reset_pin, out_enable_pin, format_select_pin, full_power_down, conv_over_range,
              conv_sample}),
    .q      (pins_s)
  );
  assign {sck_pos_s, sck_neg_s, sclk_s, serial_in_line_s, sen_n_s, rst_pin_s, oe_s, fmt_s, pdn_s, ovr_s, smp_s} = pins_s;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic sck_lvl, sck_lvl_reg, sclk_reg, sck_rise, sclk_fall;
  assign sck_lvl   = sck_pos_s & ~sck_neg_s;
  assign sck_rise  = sck_lvl & ~sck_lvl_reg;
  assign sclk_fall = sclk_reg & ~sclk_s;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_lvl_reg <= 1'b0;
      sclk_reg    <= 1'b0;
    end else begin
      sck_lvl_reg <= sck_lvl;
      sclk_reg    <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [aoc_pkg::CFG_W-1:0] cfg_reg, cfg_next;
  logic [aoc_pkg::STAT_W-1:0] status;
  logic bus_wr;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign bus_wr          = avs_write & ack_reg & (avs_address == aoc_pkg::ADR_CTRL);

  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read & ~ack_reg) begin
      unique case (avs_address)
        aoc_pkg::ADR_CTRL:   rdata_next = {{(32-aoc_pkg::CFG_W){1'b0}}, cfg_reg};
        aoc_pkg::ADR_STATUS: rdata_next = {{(32-aoc_pkg::STAT_W){1'b0}}, status};
        default:             rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // serial interface and configuration
  // ----------------------------------------------------------------
  logic [15:0] ser_sh_reg, ser_sh_next;
  logic [3:0]  ser_cnt_reg, ser_cnt_next;
  logic [7:0]  rd_sh_reg, rd_sh_next;
  logic        ser_act;
  logic [15:0] ser_word;

  assign ser_act  = ~rst_pin_s & ~sen_n_s; // R02 R03 R05
  assign ser_word = {ser_sh_reg[14:0], serial_in_line_s};

  always_comb begin
    ser_sh_next  = ser_sh_reg;
    ser_cnt_next = ser_cnt_reg;
    rd_sh_next   = rd_sh_reg;
    cfg_next     = cfg_reg;
    if (!ser_act) begin
      ser_cnt_next = 4'h0; // R02 R05
      rd_sh_next   = 8'h00;
    end else if (sclk_fall) begin
      ser_sh_next  = ser_word; // R03
      ser_cnt_next = ser_cnt_reg + aoc_pkg::SER_ONE;
      rd_sh_next   = {rd_sh_reg[6:0], 1'b0};
      if (ser_cnt_reg == aoc_pkg::SER_ADDR_LAST && ser_word[7:0] == aoc_pkg::SER_CFG_ADDR)
        rd_sh_next = {{(8-aoc_pkg::CFG_W){1'b0}}, cfg_reg}; // R01
    end
    if (bus_wr)
      cfg_next = avs_writedata[aoc_pkg::CFG_W-1:0];
    if (ser_act && sclk_fall && ser_cnt_reg == aoc_pkg::SER_WORD_LAST) begin
      if (ser_word[15:8] == aoc_pkg::SER_CFG_ADDR)
        cfg_next = ser_word[aoc_pkg::CFG_W-1:0];
      else if (ser_word[15:8] == aoc_pkg::SER_RST_ADDR && ser_word[aoc_pkg::SER_RST_BIT])
        cfg_next = aoc_pkg::CFG_RST;
    end
    if (rst_pin_s)
      cfg_next = aoc_pkg::CFG_RST; // R06
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ser_sh_reg  <= 16'h0000;
      ser_cnt_reg <= 4'h0;
      rd_sh_reg   <= 8'h00;
      cfg_reg     <= aoc_pkg::CFG_RST;
    end else begin
      ser_sh_reg  <= ser_sh_next;
      ser_cnt_reg <= ser_cnt_next;
      rd_sh_reg   <= rd_sh_next;
      cfg_reg     <= cfg_next;
    end
  end

  a_serial_idle: assert property (@(posedge clock) disable iff (!arst_n) // R02
    rst_pin_s |=> ser_cnt_reg == 4'h0 && rd_sh_reg == 8'h00)
    else $error("serial shifter ran with reset pin high");
  a_cfg_default: assert property (@(posedge clock) disable iff (!arst_n) // R06
    rst_pin_s |=> cfg_reg == aoc_pkg::CFG_RST)
    else $error("configuration left defaults while reset pin high");

  // ----------------------------------------------------------------
  // power state and wake-up
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_WAKE} aoc_pwr_t;
  aoc_pwr_t pwr_reg, pwr_next;
  logic [WAKE_W-1:0] wake_reg, wake_next;
  logic pd_reg, pd_next, sleep_req;

  assign sleep_req = pdn_s | (rst_pin_s & serial_in_line_s); // R04

  always_comb begin
    pwr_next  = pwr_reg;
    wake_next = wake_reg;
    pd_next   = pd_reg;
    unique case (pwr_reg)
      PS_RUN: begin
        if (sleep_req) begin
          pwr_next = PS_SLEEP;
          pd_next  = pdn_s;
        end
      end
      PS_SLEEP: begin
        pd_next = pd_reg | pdn_s;
        if (!sleep_req) begin
          pwr_next  = PS_WAKE;
          wake_next = pd_reg ? WAKE_W'(WAKE_PD_CYC) : WAKE_W'(WAKE_SB_CYC); // R16 R17
        end
      end
      PS_WAKE: begin
        if (sleep_req) begin
          pwr_next = PS_SLEEP;
          pd_next  = pdn_s;
        end else if (wake_reg <= WAKE_W'(1)) begin
          pwr_next = PS_RUN;
        end else begin
          wake_next = wake_reg - WAKE_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg  <= PS_RUN;
      wake_reg <= '0;
      pd_reg   <= 1'b0;
    end else begin
      pwr_reg  <= pwr_next;
      wake_reg <= wake_next;
      pd_reg   <= pd_next;
    end
  end

  assign data_valid     = (pwr_reg == PS_RUN);
  assign standby_active = (pwr_reg == PS_SLEEP);

  a_standby_pin: assert property (@(posedge clock) disable iff (!arst_n) // R04
    rst_pin_s && serial_in_line_s |=> !data_valid)
    else $error("standby pin did not stop the data");
  a_wake_bound: assert property (@(posedge clock) disable iff (!arst_n) // R16
    $fell(standby_active) && !pd_reg |=> wake_reg <= WAKE_W'(WAKE_SB_CYC))
    else $error("standby wake time exceeded");

  // ----------------------------------------------------------------
  // latency pipeline and output formatting
  // ----------------------------------------------------------------
  logic [aoc_pkg::SMP_W:0] pipe_reg [aoc_pkg::PIPE_DEPTH];
  logic [aoc_pkg::SMP_W:0] pipe_next [aoc_pkg::PIPE_DEPTH];
  logic [aoc_pkg::SMP_W:0] word_reg, word_next;
  logic [aoc_pkg::PAIRS-1:0] pair_reg, pair_next;
  logic clk_out_reg, range_reg, range_next;
  logic [aoc_pkg::LAT_W-1:0] lat;
  logic ddr_mode, off_bin;

  always_comb begin
    if (!cfg_reg[aoc_pkg::CFG_LOWLAT_OFF])
      lat = aoc_pkg::LAT_LOW; // R13
    else if (cfg_reg[aoc_pkg::CFG_OFFS_EN])
      lat = aoc_pkg::LAT_FULL; // R15
    else
      lat = aoc_pkg::LAT_GAIN; // R14
    if (cfg_reg[aoc_pkg::CFG_LONG_PATH])
      lat = lat + aoc_pkg::LAT_ONE; // R18
  end

  // R12 R19
  assign ddr_mode = (fmt_s == aoc_pkg::FMT_TC_DDR) || (fmt_s == aoc_pkg::FMT_OB_DDR);
  assign off_bin  = (fmt_s == aoc_pkg::FMT_OB_PAR) || (fmt_s == aoc_pkg::FMT_OB_DDR);

  always_comb begin
    pipe_next = pipe_reg;
    word_next = word_reg;
    if (sck_rise) begin
      pipe_next[0] = {ovr_s, smp_s};
      for (int i = 1; i < aoc_pkg::PIPE_DEPTH; i++)
        pipe_next[i] = pipe_reg[i-1];
      word_next = data_valid ? pipe_reg[lat - aoc_pkg::LAT_ONE] : '0; // R20 R16 R17
      word_next[aoc_pkg::SMP_W-1] = word_next[aoc_pkg::SMP_W-1] ^ (off_bin & data_valid); // R12
    end
    range_next = cfg_reg[aoc_pkg::CFG_READOUT] ? rd_sh_reg[7] : word_reg[aoc_pkg::SMP_W]; // R01
  end

  // R09: high half of the output clock carries even bits, low half odd bits
  genvar g;
  generate
    for (g = 0; g < aoc_pkg::PAIRS; g++) begin : g_pair
      assign pair_next[g] = ddr_mode & (sck_lvl_reg ? word_reg[2*g] : word_reg[2*g+1]);
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < aoc_pkg::PIPE_DEPTH; i++)
        pipe_reg[i] <= '0;
      word_reg    <= '0;
      pair_reg    <= '0;
      clk_out_reg <= 1'b0;
      range_reg   <= 1'b0;
    end else begin
      pipe_reg    <= pipe_next;
      word_reg    <= word_next;
      pair_reg    <= pair_next;
      clk_out_reg <= sck_lvl_reg;
      range_reg   <= range_next;
    end
  end

  assign pair_true             = pair_reg & {aoc_pkg::PAIRS{ddr_mode}}; // R11
  assign pair_comp             = ~pair_reg & {aoc_pkg::PAIRS{ddr_mode}};
  assign pair_oe               = oe_s & ddr_mode; // R08
  assign out_clock_true        = clk_out_reg & ddr_mode; // R10
  assign out_clock_comp        = ~clk_out_reg & ddr_mode; // R10 R11
  assign out_clock_comp_oe     = oe_s & ddr_mode;
  assign parallel_data         = word_reg[aoc_pkg::SMP_W-1:0] & {aoc_pkg::SMP_W{~ddr_mode}}; // R11
  assign parallel_out_clock    = clk_out_reg & ~ddr_mode;
  assign parallel_oe           = oe_s & ~ddr_mode; // R08
  assign range_flag_or_readout = range_reg;

  assign status = {~rst_pin_s, oe_s, off_bin, ddr_mode, pd_reg, standby_active, data_valid};

  a_oe_off: assert property (@(posedge clock) disable iff (!arst_n) // R08
    $fell(oe_s) |-> !pair_oe && !parallel_oe && !out_clock_comp_oe)
    else $error("drivers enabled with output enable low");
  a_comp_idle: assert property (@(posedge clock) disable iff (!arst_n) // R11
    !ddr_mode |-> !out_clock_comp && !out_clock_comp_oe && pair_true == '0)
    else $error("complement clock active in parallel mode");
  a_one_word: assert property (@(posedge clock) disable iff (!arst_n) // R20
    $changed(word_reg) |-> $past(sck_rise))
    else $error("sample word changed without a sample clock edge");
  a_lat_low: assert property (@(posedge clock) disable iff (!arst_n) // R13
    cfg_reg == aoc_pkg::CFG_RST |-> lat == 5'h0a)
    else $error("default latency is not ten");
  a_lat_full: assert property (@(posedge clock) disable iff (!arst_n) // R15
    cfg_reg[aoc_pkg::CFG_LOWLAT_OFF] && cfg_reg[aoc_pkg::CFG_OFFS_EN] && !cfg_reg[aoc_pkg::CFG_LONG_PATH]
    |-> lat == 5'h11)
    else $error("latency with offset correction is not seventeen");
  a_lat_long: assert property (@(posedge clock) disable iff (!arst_n) // R18
    cfg_reg[aoc_pkg::CFG_LONG_PATH] && !cfg_reg[aoc_pkg::CFG_LOWLAT_OFF] |-> lat == 5'h0b)
    else $error("long path did not add one cycle");
  a_range_pin: assert property (@(posedge clock) disable iff (!arst_n) // R01
    !cfg_reg[aoc_pkg::CFG_READOUT] |=> range_flag_or_readout == $past(word_reg[aoc_pkg::SMP_W]))
    else $error("range pin does not follow the sample flag");
endmodule

// *** sim/aoc_capture_model.sv ***
// Purpose: capture logic model at the converter's output pins
// Assumes: pair and output clock lines are registered on the system clock
// Notes:   rebuilds one 12-bit word per output clock period
`timescale 1ns/100ps
module aoc_capture_model (
  input  wire logic                      clock,
  input  wire logic                      out_clock_true,
  input  wire logic [aoc_pkg::PAIRS-1:0] pair_true,
  output logic      [aoc_pkg::SMP_W-1:0] cap_word,
  output logic                           cap_strobe
);
  // ----------------------------------------------------------------
  // phase capture and deinterleave
  // ----------------------------------------------------------------
  logic [aoc_pkg::PAIRS-1:0] even_q;
  logic [aoc_pkg::PAIRS-1:0] odd_q;
  logic                      prev_q;

  always @(posedge clock) begin
    prev_q <= out_clock_true;
    cap_strobe <= out_clock_true & ~prev_q;
    if (out_clock_true) begin
      even_q <= pair_true;
    end else begin
      odd_q <= pair_true;
    end
    if (out_clock_true & ~prev_q) begin
      for (int g = 0; g < aoc_pkg::PAIRS; g++) begin
        cap_word[2*g]   <= even_q[g];
        cap_word[2*g+1] <= odd_q[g];
      end
    end
  end
endmodule

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the converter output and control pins
// Assumes: short wake counts of 20 and 40 cycles
// Notes:   sample clock runs at 64 ns, unrelated in phase to clock
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sample_clock_pos = 1'b0;
  logic        sample_clock_neg = 1'b1;
  logic [11:0] conv_sample = 12'h000;
  logic        conv_over_range = 1'b0;
  logic        cfg_reset_pin = 1'b0;
  logic        serial_clock_pin = 1'b0;
  logic        serial_in_line = 1'b0;
  logic        serial_select_n = 1'b1;
  logic        out_enable_pin = 1'b1;
  logic [1:0]  format_select_pin = 2'h1;
  logic        full_power_down = 1'b0;
  logic [5:0]  pair_true;
  logic [5:0]  pair_comp;
  logic        pair_oe;
  logic        out_clock_true;
  logic        out_clock_comp;
  logic        out_clock_comp_oe;
  logic [11:0] parallel_data;
  logic        parallel_out_clock;
  logic        parallel_oe;
  logic        range_flag_or_readout;
  logic        data_valid;
  logic        standby_active;
  logic [11:0] cap_word;
  logic        cap_strobe;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #2.5 clock = ~clock;
  initial begin
    #1.3;
    forever begin
      #32;
      sample_clock_pos = ~sample_clock_pos;
      sample_clock_neg = ~sample_clock_neg;
    end
  end

  aoc_top #(.WAKE_SB_CYC(20), .WAKE_PD_CYC(40), .WAKE_W(17)) u_aoc_top (
    .clock, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sample_clock_pos, .sample_clock_neg, .conv_sample, .conv_over_range,
    .cfg_reset_pin, .serial_clock_pin, .serial_in_line, .serial_select_n, .out_enable_pin,
    .format_select_pin, .full_power_down, .pair_true, .pair_comp, .pair_oe, .out_clock_true,
    .out_clock_comp, .out_clock_comp_oe, .parallel_data, .parallel_out_clock, .parallel_oe,
    .range_flag_or_readout, .data_valid, .standby_active);
  aoc_capture_model u_aoc_capture_model (.clock, .out_clock_true, .pair_true, .cap_word, .cap_strobe);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
    check(32'(n), 32'h2, "bus answer");
  endtask

  task automatic ser_word(input logic [15:0] w, input logic sel_n);
    serial_select_n <= sel_n;
    for (int i = 15; i >= 0; i--) begin
      serial_in_line <= w[i];
      serial_clock_pin <= 1'b1;
      repeat (4) @(posedge clock);
      serial_clock_pin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    serial_select_n <= 1'b1;
    serial_in_line <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic bus_regs;
    logic [31:0] q;
    bus(1'b0, aoc_pkg::ADR_CTRL, 32'h0, q);
    check(q, 32'(aoc_pkg::CFG_RST), "ctrl default");
    bus(1'b0, aoc_pkg::ADR_STATUS, 32'h0, q);
    check(q & 32'h29, 32'h21, "status after reset");
    bus(1'b1, 4'hc, 32'h1f, q);
    bus(1'b0, 4'hc, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    $display("test bus registers done");
  endtask

  task automatic lat_run(input logic [1:0] fmt, input logic [4:0] cfg, input int exp_l, input logic [11:0] b);
    logic [31:0] q;
    logic [11:0] e;
    int          n;
    int          t;
    logic        prev;
    format_select_pin <= fmt;
    conv_sample <= ~b;
    bus(1'b1, aoc_pkg::ADR_CTRL, {27'h0, cfg}, q);
    e = (fmt == aoc_pkg::FMT_OB_PAR) ? {~b[11], b[10:0]} : b;
    repeat (25) @(posedge sample_clock_pos);
    @(negedge sample_clock_pos);
    conv_sample <= b;
    @(posedge sample_clock_pos);
    prev = 1'b1;
    n = 0;
    t = 0;
    while (parallel_data !== e && t < 2000) begin
      @(posedge clock);
      t++;
      if (sample_clock_pos && !prev) n++;
      prev = sample_clock_pos;
    end
    check(32'(n), 32'(exp_l), "latency in sample clocks");
    check(32'({pair_oe, out_clock_comp_oe, parallel_oe, pair_true}), 32'h040, "parallel lines");
    @(posedge clock);
    check(32'(parallel_out_clock), 32'h1, "parallel output clock");
    $display("test latency %0d done", exp_l);
  endtask

  task automatic ddr_run(input logic [1:0] fmt, input logic [11:0] b);
    logic [11:0] e;
    int          t;
    e = (fmt == aoc_pkg::FMT_OB_DDR) ? {~b[11], b[10:0]} : b;
    format_select_pin <= fmt;
    conv_sample <= b;
    conv_over_range <= 1'b1;
    repeat (30) @(posedge sample_clock_pos);
    @(posedge clock);
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (cap_strobe !== 1'b1 && t < 200);
    check(32'(cap_word), 32'(e), "captured pair word");
    check(32'(pair_comp ^ pair_true), 32'h3f, "pair complement");
    check(32'(out_clock_comp ^ out_clock_true), 32'h1, "output clock pair");
    check(32'({pair_oe, out_clock_comp_oe, parallel_oe}), 32'h6, "ddr enables");
    check(32'(range_flag_or_readout), 32'h1, "range flag");
    out_enable_pin <= 1'b0;
    repeat (5) @(posedge clock);
    check(32'({pair_oe, out_clock_comp_oe, parallel_oe}), 32'h0, "drivers off");
    out_enable_pin <= 1'b1;
    conv_over_range <= 1'b0;
    repeat (5) @(posedge clock);
    $display("test ddr format %0d done", fmt);
  endtask

  task automatic power_run(input logic sb, input int w);
    logic [31:0] q;
    int          n;
    if (sb) begin
      cfg_reset_pin <= 1'b1;
      serial_in_line <= 1'b1;
    end else begin
      full_power_down <= 1'b1;
    end
    repeat (10) @(posedge clock);
    bus(1'b1, aoc_pkg::ADR_CTRL, 32'h7, q);
    bus(1'b0, aoc_pkg::ADR_CTRL, 32'h0, q);
    check(q, sb ? 32'h0 : 32'h7, "ctrl under reset pin");
    if (sb) check(32'(standby_active), 32'h1, "standby");
    check(32'(data_valid), 32'h0, "asleep");
    serial_in_line <= 1'b0;
    full_power_down <= 1'b0;
    n = 0;
    while (data_valid !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    check(32'(n >= w && n <= w + 6), 32'h1, "wake time");
    cfg_reset_pin <= 1'b0;
    repeat (4) @(posedge clock);
    $display("test wake %0d done", w);
  endtask

  task automatic ser_test;
    logic [31:0] q;
    ser_word({aoc_pkg::SER_CFG_ADDR, 8'h13}, 1'b0);
    bus(1'b0, aoc_pkg::ADR_CTRL, 32'h0, q);
    check(q, 32'h13, "serial load");
    ser_word({aoc_pkg::SER_CFG_ADDR, 8'h01}, 1'b1);
    bus(1'b0, aoc_pkg::ADR_CTRL, 32'h0, q);
    check(q, 32'h13, "deselected ignored");
    ser_word({aoc_pkg::SER_RST_ADDR, 8'h80}, 1'b0);
    bus(1'b0, aoc_pkg::ADR_CTRL, 32'h0, q);
    check(q, 32'(aoc_pkg::CFG_RST), "software reset");
    conv_over_range <= 1'b1;
    bus(1'b1, aoc_pkg::ADR_CTRL, 32'h8, q);
    repeat (12) @(posedge sample_clock_pos);
    check(32'(range_flag_or_readout), 32'h0, "readout replaces range flag");
    $display("test serial done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    bus_regs();
    lat_run(aoc_pkg::FMT_TC_PAR, 5'h00, 10, 12'h9a5);
    lat_run(aoc_pkg::FMT_TC_PAR, 5'h03, 16, 12'h3c6);
    lat_run(aoc_pkg::FMT_TC_PAR, 5'h07, 17, 12'h871);
    lat_run(aoc_pkg::FMT_OB_PAR, 5'h10, 11, 12'h2e4);
    ddr_run(aoc_pkg::FMT_TC_DDR, 12'h5c3);
    ddr_run(aoc_pkg::FMT_OB_DDR, 12'h5c3);
    power_run(1'b1, 20);
    power_run(1'b0, 40);
    ser_test();
    tally_and_finish();
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end
endmodule
